//--- inc/acl_pkg.sv
package acl_pkg;

    // ------------------------------------------------------------
    // Register pointers
    // ------------------------------------------------------------
    localparam logic [3:0] PTR_RESULT = 4'h0;
    localparam logic [3:0] PTR_ALERT = 4'h1;
    localparam logic [3:0] PTR_CONFIG = 4'h2;
    localparam logic [3:0] PTR_TIMER = 4'h3;
    localparam logic [3:0] PTR_LIMIT_BASE = 4'h4;
    localparam logic [3:0] LIMIT_STRIDE = 4'h3;
    localparam logic [1:0] KIND_LOWER = 2'h0;
    localparam logic [1:0] KIND_UPPER = 2'h1;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_RESET = 12'h008;
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam int CFG_FILTER_BIT = 3;
    localparam int CFG_SEL_LSB = 4;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_BUSY = 2'h1;
    localparam logic [1:0] MODE_ALERT = 2'h2;
    localparam logic [1:0] MODE_CLEAR = 2'h3;

    // ------------------------------------------------------------
    // Result word and limit values
    // ------------------------------------------------------------
    localparam int RES_FLAG_BIT = 15;
    localparam int RES_TAG_LSB = 12;
    localparam logic [7:0] ALERT_CLEAR_ALL = 8'hFF;
    localparam logic [11:0] UPPER_RESET_12 = 12'hFFF;
    localparam logic [11:0] UPPER_RESET_10 = 12'hFFC;
    localparam logic [11:0] LOWER_RESET = 12'h000;
    localparam logic [11:0] HYST_RESET_12 = 12'h008;
    localparam logic [11:0] HYST_RESET_10 = 12'h002;
    localparam logic PIN_RESET = 1'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } acl_wr_byte_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_LOOK = 4'b0100,
        ST_EVAL = 4'b1000
    } acl_state_t;

endpackage

//--- rtl/acl_limit_mem.sv
`timescale 1ns/1ps
`default_nettype none

module acl_limit_mem import acl_pkg::*; #(
    parameter bit TEN_BIT = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [11:0] wrData,
    input wire logic [3:0] rdAddr,
    output logic [11:0] rdData_q,
    input wire logic [1:0] lkChan,
    output logic [11:0] lkLow_q,
    output logic [11:0] lkHigh_q,
    output logic [11:0] lkHyst_q
);

    logic [11:0] memQ [0:15];
    logic [3:0] lkBase;

    // Power-up value of one limit slot
    function automatic logic [11:0] resetValue(input logic [3:0] a);
        logic [3:0] k;
        k = 4'((a - PTR_LIMIT_BASE) % LIMIT_STRIDE);
        if (a < PTR_LIMIT_BASE)
            resetValue = 12'h000;
        else if (k[1:0] == KIND_LOWER)
            resetValue = LOWER_RESET;
        else if (k[1:0] == KIND_UPPER)
            resetValue = TEN_BIT ? UPPER_RESET_10 : UPPER_RESET_12;
        else
            resetValue = TEN_BIT ? HYST_RESET_10 : HYST_RESET_12;
    endfunction

    assign lkBase = 4'(PTR_LIMIT_BASE + LIMIT_STRIDE * {2'h0, lkChan});

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                memQ[i] <= resetValue(4'(i));
        end
        else if (wrEn && wrAddr >= PTR_LIMIT_BASE)
            memQ[wrAddr] <= wrData;
    end

    always_ff @(posedge core_clk)
    begin
        rdData_q <= memQ[rdAddr];
        lkLow_q <= memQ[lkBase];
        lkHigh_q <= memQ[4'(lkBase + 4'h1)];
        lkHyst_q <= memQ[4'(lkBase + 4'h2)];
    end

endmodule

`default_nettype wire

//--- rtl/acl_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Config is 12 bits, written as two bytes
// - Config resets to zero except filter bit
// - Bits D11..D4 select channels 8..1
// - Sequence selected channels from lowest upward
// - D3 enables or bypasses bus glitch filter
// - D0 sets status pin active level
// - D2..D1 pick none, busy or alert
// - Code 11 clears pin, flag, status
// - After code 11, readback shows 10
// - Result is read-only, read as two bytes
// - Result holds flag, channel tag, data
// - Ten-bit variant returns two zero LSBs
// - Flag set while any channel violates
// - Only channels 1-4 have 12-bit limits
// - Upper resets full scale, lower zero
// - Result above upper limit raises alert
// - Upper alert released N codes below
// - Clearing code also releases alert pin
// - Violation shown on pin and/or flag
// - Below lower limit alerts, N above releases
// - Hysteresis resets to 2 or 8
// - All-ones write clears alert status
// - Pointer low nibble selects target register
module acl_regs import acl_pkg::*; #(
    parameter bit TEN_BIT = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire acl_wr_byte_t wrByte,
    input wire logic rdReq,
    output logic [7:0] rdData_q,
    output logic rdValid_q,
    input wire logic convStart,
    input wire logic convDone,
    input wire logic [11:0] convData,
    output logic [2:0] convChannel_q,
    output logic statusPin_q,
    output logic glitchFilterEn_q,
    output logic [7:0] channelSelect_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    acl_state_t stateQ, stateD;
    logic [11:0] cfgQ;
    logic [3:0] ptrQ;
    logic wrIdxQ;
    logic [7:0] wrHiQ;
    logic rdIdxQ;
    logic [7:0] rdLoQ;
    logic [2:0] seqPosQ;
    logic [11:0] resultQ;
    logic [2:0] tagQ;
    logic [7:0] activeQ;
    logic [7:0] statusQ;
    logic [11:0] memRd;
    logic [11:0] lkLow;
    logic [11:0] lkHigh;
    logic [11:0] lkHyst;

    // Lowest selected channel at or after a start position, wrapping
    function automatic logic [2:0] nextSel(input logic [7:0] sel, input logic [2:0] from);
        logic found;
        logic [2:0] idx;
        found = 1'b0;
        nextSel = from;
        for (int i = 0; i < 8; i++)
        begin
            idx = 3'(from + 3'(i));
            if (!found && sel[idx])
            begin
                found = 1'b1;
                nextSel = idx;
            end
        end
    endfunction

    // Place lower/upper bits of one channel into status layout
    function automatic logic [7:0] chanBits(input logic [1:0] ch, input logic lo,
                                            input logic hi);
        chanBits = 8'h00;
        chanBits[{ch, 1'b0}] = lo;
        chanBits[{ch, 1'b1}] = hi;
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire dataByte = wrByte.valid & ~wrByte.first;
    wire wordDone = dataByte & wrIdxQ;
    wire [11:0] wrWord = {wrHiQ[3:0], wrByte.data};
    wire cfgWrite = wordDone & (ptrQ == PTR_CONFIG);
    wire clearCode = cfgWrite & (wrWord[2:1] == MODE_CLEAR);
    wire statusWrite = dataByte & ~wrIdxQ & (ptrQ == PTR_ALERT);
    wire statusClear = clearCode | (statusWrite & (wrByte.data == ALERT_CLEAR_ALL));
    wire limitWrite = wordDone & (ptrQ >= PTR_LIMIT_BASE);
    wire [11:0] cfgD = {wrWord[11:3], clearCode ? MODE_ALERT : wrWord[2:1], wrWord[0]};

    wire [7:0] selBits = cfgQ[CFG_SEL_LSB +: 8];
    wire [1:0] pinMode = cfgQ[CFG_MODE_LSB +: 2];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ptrQ <= PTR_RESULT;
            wrIdxQ <= 1'b0;
            wrHiQ <= 8'h00;
        end
        else if (wrByte.valid && wrByte.first)
        begin
            ptrQ <= wrByte.data[3:0];
            wrIdxQ <= 1'b0;
        end
        else if (dataByte)
        begin
            wrIdxQ <= ~wrIdxQ;
            wrHiQ <= wrByte.data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            cfgQ <= CFG_RESET;
        else if (cfgWrite)
            cfgQ <= cfgD;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            glitchFilterEn_q <= CFG_RESET[CFG_FILTER_BIT];
            channelSelect_q <= 8'h00;
        end
        else
        begin
            glitchFilterEn_q <= cfgQ[CFG_FILTER_BIT];
            channelSelect_q <= selBits;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    wire startOk = convStart & (|selBits);
    wire [11:0] convMasked = TEN_BIT ? {convData[11:2], 2'h0} : convData;

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            ST_IDLE: if (startOk) stateD = ST_CONV;
            ST_CONV: if (convDone) stateD = ST_LOOK;
            ST_LOOK: stateD = ST_EVAL;
            ST_EVAL: stateD = ST_IDLE;
            default: stateD = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            stateQ <= ST_IDLE;
        else
            stateQ <= stateD;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            seqPosQ <= 3'h0;
            convChannel_q <= 3'h0;
        end
        else if (cfgWrite)
            seqPosQ <= 3'h0;
        else if (stateQ == ST_IDLE && startOk)
            convChannel_q <= nextSel(selBits, seqPosQ);
        else if (stateQ == ST_CONV && convDone)
            seqPosQ <= 3'(convChannel_q + 3'h1);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            resultQ <= 12'h000;
            tagQ <= 3'h0;
        end
        else if (stateQ == ST_CONV && convDone)
        begin
            resultQ <= convMasked;
            tagQ <= convChannel_q;
        end
    end

    // ------------------------------------------------------------
    // Limit checking
    // ------------------------------------------------------------
    wire evalNow = (stateQ == ST_EVAL) & ~tagQ[2];
    wire aboveHigh = resultQ > lkHigh;
    wire belowLow = resultQ < lkLow;
    wire relHigh = ({1'b0, resultQ} + {1'b0, lkHyst}) <= {1'b0, lkHigh};
    wire relLow = {1'b0, resultQ} >= ({1'b0, lkLow} + {1'b0, lkHyst});
    wire [7:0] setMask = evalNow ? chanBits(tagQ[1:0], belowLow, aboveHigh) : 8'h00;
    wire [7:0] relMask = evalNow ? chanBits(tagQ[1:0], relLow, relHigh) : 8'h00;
    wire anyAlert = |activeQ;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            activeQ <= 8'h00;
            statusQ <= 8'h00;
        end
        else
        begin
            activeQ <= (activeQ & ~(statusClear ? 8'hFF : relMask)) | setMask;
            statusQ <= (statusClear ? 8'h00 : statusQ) | setMask;
        end
    end

    // ------------------------------------------------------------
    // Status pin
    // ------------------------------------------------------------
    wire pinActive = (pinMode == MODE_BUSY) ? (stateQ == ST_CONV) :
                     (pinMode == MODE_ALERT) ? anyAlert : 1'b0;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            statusPin_q <= PIN_RESET;
        else
            statusPin_q <= pinActive ~^ cfgQ[CFG_POL_BIT];
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [15:0] resultWord = {anyAlert, tagQ, resultQ};
    wire wideReg = (ptrQ != PTR_ALERT) && (ptrQ != PTR_TIMER);
    wire [15:0] liveWord = (ptrQ == PTR_RESULT) ? resultWord :
                           (ptrQ == PTR_CONFIG) ? {4'h0, cfgQ} :
                           (ptrQ >= PTR_LIMIT_BASE) ? {4'h0, memRd} : 16'h0000;
    wire [7:0] byteReg = (ptrQ == PTR_ALERT) ? statusQ : 8'h00;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
            rdIdxQ <= 1'b0;
            rdLoQ <= 8'h00;
        end
        else
        begin
            rdValid_q <= rdReq;
            if (wrByte.valid && wrByte.first)
                rdIdxQ <= 1'b0;
            else if (rdReq && !wideReg)
                rdData_q <= byteReg;
            else if (rdReq && !rdIdxQ)
            begin
                rdData_q <= liveWord[15:8];
                rdLoQ <= liveWord[7:0];
                rdIdxQ <= 1'b1;
            end
            else if (rdReq)
            begin
                rdData_q <= rdLoQ;
                rdIdxQ <= 1'b0;
            end
        end
    end

    acl_limit_mem #(
        .TEN_BIT(TEN_BIT)
    ) u_mem (
        .core_clk(core_clk),
        .reset(reset),
        .wrEn(limitWrite),
        .wrAddr(ptrQ),
        .wrData(wrWord),
        .rdAddr(ptrQ),
        .rdData_q(memRd),
        .lkChan(convChannel_q[1:0]),
        .lkLow_q(lkLow),
        .lkHigh_q(lkHigh),
        .lkHyst_q(lkHyst)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence sqClearWrite;
        clearCode && setMask == 8'h00;
    endsequence

    sequence sqAlertCleared;
        statusQ == 8'h00 && activeQ == 8'h00;
    endsequence

    chk_cfg_reset_val: assert property ($fell(reset) |-> cfgQ == CFG_RESET)
        else $error("config not at reset value");

    chk_clear_readback: assert property (cfgWrite && wrWord[2:1] == MODE_CLEAR
        |=> cfgQ[2:1] == MODE_ALERT)
        else $error("clear code readback wrong");

    chk_clear_alerts: assert property (sqClearWrite |=> sqAlertCleared)
        else $error("clear code left alert state");

    chk_status_ones: assert property (statusWrite && wrByte.data == ALERT_CLEAR_ALL
        && setMask == 8'h00 |=> statusQ == 8'h00)
        else $error("all ones did not clear status");

    chk_chan_selected: assert property (stateQ == ST_CONV |-> selBits[convChannel_q]
        || $past(cfgWrite))
        else $error("converting unselected channel");

    chk_upper_trip: assert property (evalNow && aboveHigh |=> activeQ[{tagQ[1:0], 1'b1}]
        && statusQ[{tagQ[1:0], 1'b1}])
        else $error("upper violation not flagged");

    chk_lower_trip: assert property (evalNow && belowLow |=> activeQ[{tagQ[1:0], 1'b0}])
        else $error("lower violation not flagged");

    chk_busy_pin: assert property (pinMode == MODE_BUSY && stateQ == ST_CONV
        ##1 pinMode == MODE_BUSY |-> statusPin_q == $past(cfgQ[CFG_POL_BIT]))
        else $error("busy pin not active in conversion");

    chk_flag_read: assert property (rdReq && wideReg && !rdIdxQ && ptrQ == PTR_RESULT
        && anyAlert && !(wrByte.valid && wrByte.first) |=> rdValid_q && rdData_q[7])
        else $error("result flag missing during alert");

    chk_ten_bit_lsb: assert property (stateQ == ST_LOOK |-> !TEN_BIT
        || resultQ[1:0] == 2'h0)
        else $error("ten bit result lsbs not zero");

    chk_filter_follow: assert property (##1 glitchFilterEn_q == $past(cfgQ[CFG_FILTER_BIT]))
        else $error("filter enable does not follow config");

endmodule

`default_nettype wire

//--- testbench/acl_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Serial engine side: byte writes and byte reads
// ------------------------------------------------------------
module acl_master_model import acl_pkg::*; (
    input wire logic core_clk,
    output var acl_wr_byte_t wrByte,
    output var logic rdReq,
    input wire logic [7:0] rdData_q,
    input wire logic rdValid_q
);
    initial
    begin
        wrByte = '0;
        rdReq = 1'b0;
    end

    task automatic put(input logic first, input logic [7:0] data);
        @(posedge core_clk);
        wrByte <= '{valid: 1'b1, first: first, data: data};
        @(posedge core_clk);
        wrByte <= '0;
    endtask

    // Answer lands one cycle after the request edge
    task automatic get(output logic [7:0] data);
        @(posedge core_clk);
        rdReq <= 1'b1;
        @(posedge core_clk);
        rdReq <= 1'b0;
        @(negedge core_clk);
        data = (rdValid_q === 1'b1) ? rdData_q : 8'hXX;
    endtask

    task automatic wr16(input logic [3:0] ptr, input logic [15:0] val);
        put(1'b1, {4'h0, ptr});
        put(1'b0, val[15:8]);
        put(1'b0, val[7:0]);
    endtask

    task automatic wr8(input logic [3:0] ptr, input logic [7:0] val);
        put(1'b1, {4'h0, ptr});
        put(1'b0, val);
    endtask

    task automatic rd16(input logic [3:0] ptr, output logic [15:0] val);
        logic [7:0] hi;
        logic [7:0] lo;
        put(1'b1, {4'h0, ptr});
        get(hi);
        get(lo);
        val = {hi, lo};
    endtask

    task automatic rd8(input logic [3:0] ptr, output logic [7:0] val);
        put(1'b1, {4'h0, ptr});
        get(val);
    endtask
endmodule

`default_nettype wire

//--- testbench/tb_acl_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_acl_regs import acl_pkg::*;;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    acl_wr_byte_t wrByte;
    logic rdReq;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic convStart = 1'b0;
    logic convDone = 1'b0;
    logic [11:0] convData = 12'h000;
    logic [2:0] convChannel_q;
    logic statusPin_q;
    logic glitchFilterEn_q;
    logic [7:0] channelSelect_q;
    logic [7:0] rdDataTen;
    logic [11:0] cfg = CFG_RESET;
    logic [11:0] v;
    logic [15:0] w;
    logic [7:0] b;
    int pos = 0;
    int failures = 0;
    int check_count = 0;

    always #10 core_clk = ~core_clk;

    acl_regs #(.TEN_BIT(1'b0)) i_dut (
        .core_clk(core_clk),
        .reset(reset),
        .wrByte(wrByte),
        .rdReq(rdReq),
        .rdData_q(rdData_q),
        .rdValid_q(rdValid_q),
        .convStart(convStart),
        .convDone(convDone),
        .convData(convData),
        .convChannel_q(convChannel_q),
        .statusPin_q(statusPin_q),
        .glitchFilterEn_q(glitchFilterEn_q),
        .channelSelect_q(channelSelect_q)
    );

    // Ten-bit variant fed the same traffic, read bytes watched
    acl_regs #(.TEN_BIT(1'b1)) i_dut_ten (
        .core_clk(core_clk),
        .reset(reset),
        .wrByte(wrByte),
        .rdReq(rdReq),
        .rdData_q(rdDataTen),
        .rdValid_q(),
        .convStart(convStart),
        .convDone(convDone),
        .convData(convData),
        .convChannel_q(),
        .statusPin_q(),
        .glitchFilterEn_q(),
        .channelSelect_q()
    );

    acl_master_model i_mst (
        .core_clk(core_clk),
        .wrByte(wrByte),
        .rdReq(rdReq),
        .rdData_q(rdData_q),
        .rdValid_q(rdValid_q)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Lowest selected channel at or after the sequence position, wrapping
    function automatic logic [2:0] pick(input logic [7:0] sel, input int from);
        for (int i = 0; i < 8; i++)
            if (sel[(from + i) % 8])
                return 3'((from + i) % 8);
        return 3'h0;
    endfunction

    task automatic wcfg(input logic [11:0] val);
        i_mst.wr16(PTR_CONFIG, {4'hF, val});
        cfg = (val[2:1] == MODE_CLEAR) ? {val[11:3], MODE_ALERT, val[0]} : val;
        pos = 0;
        repeat (2) @(negedge core_clk);
        check("select", 16'(channelSelect_q), 16'(cfg[11:4]));
        check("filter", 16'(glitchFilterEn_q), 16'(cfg[3]));
        i_mst.rd16(PTR_CONFIG, w);
        check("config", w, {4'h0, cfg});
    endtask

    task automatic conv(input logic [11:0] d, input logic flag);
        logic [2:0] ch;
        logic pinExp;
        ch = pick(cfg[11:4], pos);
        @(posedge core_clk);
        convStart <= 1'b1;
        @(posedge core_clk);
        convStart <= 1'b0;
        @(negedge core_clk);
        check("channel", 16'(convChannel_q), 16'(ch));
        @(posedge core_clk);
        convDone <= 1'b1;
        convData <= d;
        @(negedge core_clk);
        if (cfg[2:1] == MODE_BUSY)
            check("busy", 16'(statusPin_q), 16'(cfg[0]));
        @(posedge core_clk);
        convDone <= 1'b0;
        convData <= ~d;
        pos = (ch + 1) % 8;
        repeat (8) @(negedge core_clk);
        pinExp = (cfg[2:1] == MODE_ALERT && flag) ? cfg[0] : !cfg[0];
        check("pin", 16'(statusPin_q), 16'(pinExp));
        i_mst.rd16(PTR_RESULT, w);
        check("result", w, {flag, ch, d});
        check("ten lsb", 16'(rdDataTen[1:0]), 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(23981));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check("pin reset", 16'(statusPin_q), 16'h0001);
        check("filter reset", 16'(glitchFilterEn_q), 16'h0001);
        i_mst.rd16(PTR_CONFIG, w);
        check("config reset", w, 16'h0008);
        i_mst.rd16(4'h4, w);
        check("lower reset", w, 16'h0000);
        i_mst.rd16(4'h5, w);
        check("upper reset", w, 16'h0FFF);
        check("upper reset ten", 16'(rdDataTen), 16'h00FC);
        i_mst.rd16(4'h6, w);
        check("hyst reset", w, 16'h0008);
        check("hyst reset ten", 16'(rdDataTen), 16'h0002);
        i_mst.wr8(PTR_CONFIG, 8'h0F);
        i_mst.rd16(PTR_CONFIG, w);
        check("lone byte", w, 16'h0008);
        for (int k = 0; k < 6; k++)
        begin
            v = {8'($urandom_range(1, 255)), 1'($urandom), k[0] ? MODE_BUSY : MODE_NONE,
                 1'($urandom)};
            wcfg(v);
            repeat (3) conv(12'($urandom), 1'b0);
        end
        wcfg(12'h014);
        i_mst.wr16(4'h5, 16'hF100);
        i_mst.rd16(4'h5, w);
        check("upper", w, 16'h0100);
        conv(12'h200, 1'b1);
        i_mst.rd8(PTR_ALERT, b);
        check("status hi", 16'(b), 16'h0002);
        conv(12'h0F9, 1'b1);
        conv(12'h0F8, 1'b0);
        conv(12'h300, 1'b1);
        wcfg(12'h016);
        check("pin clear", 16'(statusPin_q), 16'h0001);
        i_mst.rd8(PTR_ALERT, b);
        check("status clear", 16'(b), 16'h0000);
        i_mst.rd16(PTR_RESULT, w);
        check("flag clear", w, 16'h0300);
        i_mst.wr16(4'h4, 16'h0080);
        conv(12'h07F, 1'b1);
        i_mst.wr8(PTR_ALERT, 8'h55);
        i_mst.rd8(PTR_ALERT, b);
        check("status lo", 16'(b), 16'h0001);
        i_mst.wr8(PTR_ALERT, ALERT_CLEAR_ALL);
        i_mst.rd8(PTR_ALERT, b);
        check("status wipe", 16'(b), 16'h0000);
        close_out();
    end

    initial
    begin
        #400000;
        failures++;
        close_out();
    end
endmodule

`default_nettype wire
